// [pkg/result_regs_defs.svh]
`ifndef RESULT_REGS_DEFS_SVH
`define RESULT_REGS_DEFS_SVH

`define ADDR_PRESS_LOW   8'h28
`define ADDR_PRESS_MID   8'h29
`define ADDR_PRESS_HIGH  8'h2A
`define ADDR_TEMP_LOW    8'h2B
`define ADDR_TEMP_HIGH   8'h2C
`define ADDR_STATUS      8'h27
`define STAT_P_AVAIL     0
`define STAT_T_AVAIL     1
`define STAT_P_OVR       4
`define STAT_T_OVR       5
`define RESET_BYTE       8'h00
`define PRESS_WIDTH      24
`define TEMP_WIDTH       16
`define RAW_WIDTH        26

`endif

// [pkg/result_regs_pkg.sv]
package result_regs_pkg;

    // host register access, one byte per cycle
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_type;

    // stored results and flags
    typedef struct packed {
        logic [23:0] pressure;
        logic [15:0] temperature;
        logic        p_avail;
        logic        t_avail;
        logic        p_ovr;
        logic        t_ovr;
    } result_state_type;

    typedef enum logic [1:0] {
        FLAG_IDLE,
        FLAG_SET,
        FLAG_CLEAR
    } flag_event_type;

endpackage

// [rtl/event_flag.sv]
`timescale 1ns/1ps
`default_nettype none
module event_flag (
    // clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // events
    input  wire logic set_event,
    input  wire logic clear_event,
    // flag
    output logic      flag
);
    logic flag_reg;
    logic flag_next;

    // a set in the clearing cycle wins so no sample goes unnoticed
    always_comb begin
        if (set_event) begin
            flag_next = 1'b1;
        end else if (clear_event) begin
            flag_next = 1'b0;
        end else begin
            flag_next = flag_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign flag = flag_reg;
endmodule
`default_nettype wire

// [rtl/pressure_clipper.sv]
`timescale 1ns/1ps
`default_nettype none
`include "result_regs_defs.svh"
module pressure_clipper #(
    parameter int RAW_W = `RAW_WIDTH,
    parameter int OUT_W = `PRESS_WIDTH
) (
    // raw measurement and reference
    input  wire logic signed [RAW_W-1:0] measured,
    input  wire logic signed [RAW_W-1:0] reference,
    // limits of the operating range, as differences
    input  wire logic signed [OUT_W-1:0] range_max,
    input  wire logic signed [OUT_W-1:0] range_min,
    // clipped difference
    output logic signed [OUT_W-1:0]      result
);
    logic signed [RAW_W:0] diff;

    always_comb begin
        diff = {measured[RAW_W-1], measured} - {reference[RAW_W-1], reference}; // (R4)
        // saturate so a far reading never wraps into the other sign
        // concatenations are unsigned, so the limits are cast back to signed
        if (diff > $signed({{(RAW_W+1-OUT_W){range_max[OUT_W-1]}}, range_max})) begin
            result = range_max; // (R6)
        end else if (diff < $signed({{(RAW_W+1-OUT_W){range_min[OUT_W-1]}}, range_min})) begin
            result = range_min; // (R6)
        end else begin
            result = diff[OUT_W-1:0]; // (R5)
        end
    end
endmodule
`default_nettype wire

// [rtl/pressure_temp_output_regs.sv]
`timescale 1ns/1ps
`default_nettype none
`include "result_regs_defs.svh"
// Notes on behaviour
// (R1) pressure bits 7..0 read at 28h
// (R2) pressure bits 15..8 read at 29h
// (R3) pressure bits 23..16 read at 2Ah
// (R4) pressure is measured minus reference
// (R5) 24-bit pressure is two's complement
// (R6) out-of-range pressure saturates, never wraps
// (R7) temperature bits 7..0 read at 2Bh
// (R8) temperature bits 15..8 read at 2Ch
// (R9) 16-bit temperature is two's complement
// (R10) pressure available: set on sample, cleared by 2Ah read
// (R11) temperature available: set on sample, cleared by 2Ch read
// (R12) pressure overrun when sample meets unread data
// (R13) temperature overrun when sample meets unread data
// (R14) writes to result registers are ignored
module pressure_temp_output_regs
    import result_regs_pkg::*;
#(
    parameter int RAW_W = `RAW_WIDTH
) (
    // clock and reset
    input  wire logic                    clock,
    input  wire logic                    rst,
    // conversion engine side
    input  wire logic                    pressure_sample_valid,
    input  wire logic signed [RAW_W-1:0] pressure_measured,
    input  wire logic signed [RAW_W-1:0] pressure_reference,
    input  wire logic signed [23:0]      pressure_range_max,
    input  wire logic signed [23:0]      pressure_range_min,
    input  wire logic                    temperature_sample_valid,
    input  wire logic signed [15:0]      temperature_sample,
    // register access from the serial interface
    input  wire reg_req_type             req,
    output logic [7:0]                   rdata,
    output logic                         rdata_valid,
    // status flags
    output logic                         pressure_available_flag,
    output logic                         temperature_available_flag,
    output logic                         pressure_overrun_flag,
    output logic                         temperature_overrun_flag
);
    logic signed [23:0] pressure_clipped;
    logic [23:0]        pressure_result_bits_reg;
    logic [15:0]        temperature_result_bits_reg;
    logic [7:0]         rdata_reg;
    logic               rdata_valid_reg;
    logic               read_press_high;
    logic               read_temp_high;
    logic               p_ovr_set;
    logic               t_ovr_set;
    logic [7:0]         status_byte;

    pressure_clipper #(
        .RAW_W (RAW_W),
        .OUT_W (`PRESS_WIDTH)
    ) clipper (
        .measured  (pressure_measured),
        .reference (pressure_reference),
        .range_max (pressure_range_max),
        .range_min (pressure_range_min),
        .result    (pressure_clipped)
    );

    // results change only on a new sample; writes have no path here
    always_ff @(posedge clock) begin
        if (rst) begin
            pressure_result_bits_reg <= {`PRESS_WIDTH{1'b0}};
        end else if (pressure_sample_valid) begin
            pressure_result_bits_reg <= pressure_clipped; // (R4) (R14)
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            temperature_result_bits_reg <= {`TEMP_WIDTH{1'b0}};
        end else if (temperature_sample_valid) begin
            temperature_result_bits_reg <= temperature_sample; // (R9) (R14)
        end
    end

    // only reads clear flags, a write to the same address does nothing
    assign read_press_high = req.rd && (req.addr == `ADDR_PRESS_HIGH); // (R14)
    assign read_temp_high  = req.rd && (req.addr == `ADDR_TEMP_HIGH);
    assign p_ovr_set = pressure_sample_valid && pressure_available_flag; // (R12)
    assign t_ovr_set = temperature_sample_valid && temperature_available_flag; // (R13)

    event_flag p_avail_flag (
        .clock       (clock),
        .rst         (rst),
        .set_event   (pressure_sample_valid),
        .clear_event (read_press_high), // (R10)
        .flag        (pressure_available_flag)
    );

    event_flag t_avail_flag (
        .clock       (clock),
        .rst         (rst),
        .set_event   (temperature_sample_valid),
        .clear_event (read_temp_high), // (R11)
        .flag        (temperature_available_flag)
    );

    event_flag p_ovr_flag (
        .clock       (clock),
        .rst         (rst),
        .set_event   (p_ovr_set),
        .clear_event (read_press_high), // (R12)
        .flag        (pressure_overrun_flag)
    );

    event_flag t_ovr_flag (
        .clock       (clock),
        .rst         (rst),
        .set_event   (t_ovr_set),
        .clear_event (read_temp_high), // (R13)
        .flag        (temperature_overrun_flag)
    );

    always_comb begin
        status_byte = `RESET_BYTE;
        status_byte[`STAT_P_AVAIL] = pressure_available_flag;
        status_byte[`STAT_T_AVAIL] = temperature_available_flag;
        status_byte[`STAT_P_OVR]   = pressure_overrun_flag;
        status_byte[`STAT_T_OVR]   = temperature_overrun_flag;
    end

    // read data is registered; it shows values before this cycle's sample
    always_ff @(posedge clock) begin
        if (rst) begin
            rdata_reg <= `RESET_BYTE;
        end else if (req.rd) begin
            if (req.addr == `ADDR_PRESS_LOW) begin
                rdata_reg <= pressure_result_bits_reg[7:0]; // (R1)
            end else if (req.addr == `ADDR_PRESS_MID) begin
                rdata_reg <= pressure_result_bits_reg[15:8]; // (R2)
            end else if (req.addr == `ADDR_PRESS_HIGH) begin
                rdata_reg <= pressure_result_bits_reg[23:16]; // (R3) (R5)
            end else if (req.addr == `ADDR_TEMP_LOW) begin
                rdata_reg <= temperature_result_bits_reg[7:0]; // (R7)
            end else if (req.addr == `ADDR_TEMP_HIGH) begin
                rdata_reg <= temperature_result_bits_reg[15:8]; // (R8)
            end else if (req.addr == `ADDR_STATUS) begin
                rdata_reg <= status_byte;
            end else begin
                rdata_reg <= `RESET_BYTE;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rdata_valid_reg <= 1'b0;
        end else begin
            rdata_valid_reg <= req.rd;
        end
    end

    assign rdata       = rdata_reg;
    assign rdata_valid = rdata_valid_reg;
endmodule
`default_nettype wire

// [verification/host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module host_model
    import result_regs_pkg::*;
(
    input  wire logic       clock,
    input  wire logic [7:0] rdata,
    input  wire logic       rdata_valid,
    output var reg_req_type req
);
    initial req = '0;
    // a missing answer comes back as unknown so that any compare fails
    task automatic access(input logic w, input logic [7:0] a, d, output logic [7:0] q);
        @(negedge clock) req = '{~w, w, a, d};
        @(negedge clock) req = '0;
        q = rdata_valid === !w ? rdata : 8'hXX;
    endtask
endmodule
`default_nettype wire

// [verification/pressure_temp_output_regs_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module pressure_temp_output_regs_assertions
    import result_regs_pkg::*;
(
    // clock and reset
    input wire logic        clock,
    input wire logic        rst,
    // activity
    input wire logic        pressure_sample_valid,
    input wire logic        temperature_sample_valid,
    input wire reg_req_type req,
    input wire logic        rdata_valid,
    // flags
    input wire logic        pressure_available_flag,
    input wire logic        temperature_available_flag,
    input wire logic        pressure_overrun_flag,
    input wire logic        temperature_overrun_flag
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    wire logic p_rd = req.rd && req.addr == 8'h2A;
    wire logic t_rd = req.rd && req.addr == 8'h2C;
    wire logic quiet = !pressure_sample_valid && !temperature_sample_valid;
    rd_answer_a: assert property (req.rd |=> rdata_valid)
        else $error("read not answered");
    p_set_a: assert property (pressure_sample_valid |=> pressure_available_flag)
        else $error("pressure sample not flagged");
    t_set_a: assert property (temperature_sample_valid |=> temperature_available_flag)
        else $error("temperature sample not flagged");
    p_clear_a: assert property (p_rd && quiet |=> !pressure_available_flag
        && !pressure_overrun_flag) else $error("pressure flags kept after read");
    t_clear_a: assert property (t_rd && quiet |=> !temperature_available_flag
        && !temperature_overrun_flag) else $error("temperature flags kept after read");
    p_overrun_a: assert property (pressure_sample_valid && pressure_available_flag
        |=> pressure_overrun_flag) else $error("pressure overrun missed");
    t_overrun_a: assert property (temperature_sample_valid && temperature_available_flag
        |=> temperature_overrun_flag) else $error("temperature overrun missed");
    write_ignored_a: assert property (req.wr && !req.rd && quiet |=>
        $stable({pressure_available_flag, temperature_available_flag,
        pressure_overrun_flag, temperature_overrun_flag})) else $error("write changed flags");
    cover property (p_rd && pressure_available_flag);
    cover property (pressure_sample_valid && pressure_available_flag);
    cover property (req.wr);
endmodule
`default_nettype wire

// [verification/pressure_temp_output_regs_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module pressure_temp_output_regs_bench;
    import result_regs_pkg::*;
    logic clock = 0, rst = 1, pv = 0, tv = 0;
    logic signed [25:0] meas = '0, refp = '0;
    logic signed [23:0] pmax = 24'h0F0000, pmin = 24'hF10000;
    logic [15:0] temp = '0;
    reg_req_type req;
    logic [7:0] rdata, q;
    wire logic rdata_valid;
    wire logic [3:0] flags;
    int err_total = 0, comparisons = 0, cycles = 0;
    always #5 clock = ~clock;
    pressure_temp_output_regs i_dut(.clock, .rst, .pressure_sample_valid(pv),
        .pressure_measured(meas), .pressure_reference(refp), .pressure_range_max(pmax),
        .pressure_range_min(pmin), .temperature_sample_valid(tv), .temperature_sample(temp),
        .req, .rdata, .rdata_valid, .pressure_available_flag(flags[3]),
        .temperature_available_flag(flags[2]), .pressure_overrun_flag(flags[1]),
        .temperature_overrun_flag(flags[0]));
    host_model i_host(.clock, .rdata, .rdata_valid, .req);
    task automatic summarize;
        if (err_total == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a);
        i_host.access(0, a, 8'h00, q);
    endtask
    task automatic psamp(input logic signed [25:0] m, r);
        @(negedge clock) {meas, refp, pv} = {m, r, 1'b1};
        @(negedge clock) pv = 0;
    endtask
    task automatic pressure_case(input logic signed [25:0] m, r, input logic [23:0] e);
        psamp(m, r);
        chk(flags, 4'h8);
        rd(8'h28);
        chk(q, e[7:0]);
        rd(8'h29);
        chk(q, e[15:8]);
        rd(8'h2A);
        chk(q, e[23:16]);
        chk(flags[3], 0);
    endtask
    task automatic temp_case(input logic [15:0] v);
        @(negedge clock) {temp, tv} = {v, 1'b1};
        @(negedge clock) tv = 0;
        chk(flags, 4'h4);
        rd(8'h2B);
        chk(q, v[7:0]);
        rd(8'h2C);
        chk(q, v[15:8]);
        chk(flags[2], 0);
    endtask
    task automatic overrun_case;
        psamp(26'sd7, 26'sd2);
        psamp(26'sd9, 26'sd2);
        chk(flags[1], 1);
        @(negedge clock) {temp, tv} = {16'h0042, 1'b1};
        @(negedge clock) tv = 1;
        @(negedge clock) tv = 0;
        chk(flags[0], 1);
        rd(8'h2A);
        chk(flags[1], 0);
        rd(8'h2C);
        chk(flags, 4'h0);
        rd(8'h28);
        chk(q, 8'h07);
    endtask
    task automatic write_case;
        psamp(26'sd300, 26'sd44);
        i_host.access(1, 8'h2A, 8'h5A, q);
        i_host.access(1, 8'h29, 8'hA5, q);
        chk(flags, 4'h8);
        rd(8'h29);
        chk(q, 8'h01);
        rd(8'h27);
        chk(q, 8'h01);
        chk(flags, 4'h8);
        rd(8'h30);
        chk(q, 8'h00);
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            err_total++;
            summarize();
        end
    end
    initial begin
        repeat (5) @(posedge clock);
        @(negedge clock) rst = 0;
        pressure_case(26'sd100, 26'sd4096, 24'hFFF064);
        pressure_case(26'h0054321, 26'sd1, 24'h054320);
        pressure_case(26'h0FFFFFF, 26'sd0, 24'h0F0000);
        pressure_case(26'sd0, 26'h0FFFFFF, 24'hF10000);
        temp_case(16'h8123);
        temp_case(16'h7FFE);
        overrun_case();
        write_case();
        summarize();
    end
endmodule
bind pressure_temp_output_regs pressure_temp_output_regs_assertions i_chk(.clock, .rst,
    .pressure_sample_valid, .temperature_sample_valid, .req, .rdata_valid,
    .pressure_available_flag, .temperature_available_flag, .pressure_overrun_flag,
    .temperature_overrun_flag);
`default_nettype wire
